//--- logic/bpsc_pkg.sv
package bpsc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  // Address bus low delay after reset is sampled, in tenths of a cycle
  localparam int ADDR_INIT_TENTHS = 25;
  localparam int ADDR_INIT_CYC = (ADDR_INIT_TENTHS + 9) / 10;
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(ADDR_INIT_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_RST = 2'h0;

  // ----------------------------------------------------------------
  // Pin positions in the shared pin vector
  // ----------------------------------------------------------------
  localparam int NPIN = 10;
  localparam int PIN_PA7 = 3;
  localparam int PIN_PB0 = 4;
  localparam int PIN_PB1 = 5;
  localparam int PIN_PB2 = 6;
  localparam int PIN_PB3 = 7;
  localparam int PIN_PB4 = 8;
  localparam int PIN_PB5 = 9;

  // ----------------------------------------------------------------
  // Modes and DRAM area codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_5 = 3'h5;
  localparam logic [2:0] DRAM_AREA_4 = 3'h4;
  localparam logic [2:0] DRAM_AREA_5 = 3'h5;
  localparam logic [2:0] DRAM_AREA_6 = 3'h6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] SYNC_RST = 5'h18; // {hw_standby_n, reset_n, mode}

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SWSTBY = 3'h1,
    ST_RELEASE = 3'h2,
    ST_HWSTBY = 3'h3,
    ST_RESET = 3'h4
  } bpsc_state_e;

  typedef enum logic [2:0] {
    ROLE_IO = 3'h0,
    ROLE_ADDR = 3'h1,
    ROLE_SEL = 3'h2,
    ROLE_ROW = 3'h3,
    ROLE_COL = 3'h4
  } bpsc_role_e;

  typedef enum logic [2:0] {
    ACT_FLOAT = 3'h0,
    ACT_KEEP = 3'h1,
    ACT_HIGH = 3'h2,
    ACT_LOW = 3'h3,
    ACT_DRIVE = 3'h4,
    ACT_PORT = 3'h5
  } bpsc_act_e;

endpackage

//--- logic/bpsc_pin_cell.sv
`timescale 1ns/1ps
module bpsc_pin_cell #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire bpsc_pkg::bpsc_act_e act,
  input wire logic [W-1:0] fn_val,
  input wire logic [W-1:0] port_val,
  input wire logic [W-1:0] port_dir,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe
);

  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;
  logic [W-1:0] oe_reg;
  logic [W-1:0] oe_next;

  // Next pin level and enable from the chosen action
  always_comb begin
    out_next = out_reg;
    oe_next = oe_reg;
    case (act)
      bpsc_pkg::ACT_FLOAT: begin
        oe_next = '0;
      end
      bpsc_pkg::ACT_KEEP: begin
        out_next = out_reg; // Outputs hold, inputs stay floating
        oe_next = oe_reg;
      end
      bpsc_pkg::ACT_HIGH: begin
        out_next = '1;
        oe_next = '1;
      end
      bpsc_pkg::ACT_LOW: begin
        out_next = '0;
        oe_next = '1;
      end
      bpsc_pkg::ACT_DRIVE: begin
        out_next = fn_val;
        oe_next = '1;
      end
      bpsc_pkg::ACT_PORT: begin
        out_next = port_val;
        oe_next = port_dir;
      end
      default: begin
        oe_next = '0;
      end
    endcase
  end

  // Pin registers
  always_ff @(posedge clk) begin
    if (rst) begin
      out_reg <= '0;
      oe_reg <= '0;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  assign pin_out = out_reg;
  assign pin_oe = oe_reg;

endmodule

//--- logic/bpsc_top.sv
`timescale 1ns/1ps
module bpsc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic hw_standby_n,
  input wire logic [2:0] op_mode,
  input wire logic sw_standby,
  input wire logic bus_release,
  input wire logic standby_output_keep,
  input wire logic addr_bit23_port_select,
  input wire logic addr_bit22_port_select,
  input wire logic addr_bit21_port_select,
  input wire logic addr_bit20_port_select,
  input wire logic select7_enable,
  input wire logic select6_enable,
  input wire logic select5_enable,
  input wire logic select4_enable,
  input wire logic [2:0] dram_area_field,
  input wire logic column_strobe_select,
  input wire logic [23:0] addr_in,
  input wire logic [7:4] select_in_n,
  input wire logic row_strobe5,
  input wire logic row_strobe4,
  input wire logic upper_column_strobe,
  input wire logic lower_column_strobe,
  input wire logic addr_strobe_in_n,
  input wire logic read_in_n,
  input wire logic high_write_in_n,
  input wire logic low_write_in_n,
  input wire logic select0_in_n,
  input wire logic data_drive,
  input wire logic [3:0] pa_port_val,
  input wire logic [3:0] pa_port_dir,
  input wire logic [5:0] pb_port_val,
  input wire logic [5:0] pb_port_dir,
  output logic [3:0] pa_out,
  output logic [3:0] pa_oe,
  output logic [5:0] pb_out,
  output logic [5:0] pb_oe,
  output logic [19:0] addr_lo_out,
  output logic addr_lo_oe,
  output logic addr_strobe_n,
  output logic read_n,
  output logic high_write_n,
  output logic low_write_n,
  output logic strobes_oe,
  output logic select0_n,
  output logic select0_oe,
  output logic data_oe,
  output logic clk_pin_oe
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic [2:0] mode_s;
  logic res_s;
  logic hw_s;

  // Two flops on the hardware standby, reset and mode pin inputs
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= bpsc_pkg::SYNC_RST;
      sync_reg <= bpsc_pkg::SYNC_RST;
    end else begin
      meta_reg <= {hw_standby_n, reset_n, op_mode};
      sync_reg <= meta_reg;
    end
  end

  assign mode_s = sync_reg[2:0];
  assign res_s = sync_reg[3];
  assign hw_s = sync_reg[4];

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  logic exp_m;
  logic m14;
  logic m34;
  logic addr_m;

  // Expanded, reset-low-address and upper-address mode groups
  assign exp_m = mode_s >= bpsc_pkg::MODE_1 && mode_s <= bpsc_pkg::MODE_5;
  assign m14 = mode_s >= bpsc_pkg::MODE_1 && mode_s <= bpsc_pkg::MODE_4;
  assign m34 = mode_s == bpsc_pkg::MODE_3 || mode_s == bpsc_pkg::MODE_4;
  assign addr_m = mode_s >= bpsc_pkg::MODE_3 && mode_s <= bpsc_pkg::MODE_5;

  // ----------------------------------------------------------------
  // Pin state and reset counter
  // ----------------------------------------------------------------
  bpsc_pkg::bpsc_state_e st_reg;
  bpsc_pkg::bpsc_state_e st_next;
  logic [bpsc_pkg::CNT_W-1:0] cnt_reg;
  logic [bpsc_pkg::CNT_W-1:0] cnt_next;
  logic clk_oe_reg;
  logic clk_oe_next;
  logic data_oe_reg;
  logic data_oe_next;
  logic cnt_done;

  // State priority: hw standby, reset, sw standby, release, run
  always_comb begin
    if (!hw_s) begin
      st_next = bpsc_pkg::ST_HWSTBY;
    end else if (!res_s) begin
      st_next = bpsc_pkg::ST_RESET;
    end else if (sw_standby) begin
      st_next = bpsc_pkg::ST_SWSTBY;
    end else if (bus_release) begin
      st_next = bpsc_pkg::ST_RELEASE;
    end else begin
      st_next = bpsc_pkg::ST_RUN;
    end
    if (st_next != bpsc_pkg::ST_RESET) begin
      cnt_next = bpsc_pkg::CNT_RST;
    end else if (st_reg == bpsc_pkg::ST_RESET &&
                 cnt_reg != bpsc_pkg::CNT_LAST) begin
      cnt_next = cnt_reg + 2'h1;
    end else begin
      cnt_next = cnt_reg;
    end
    clk_oe_next = clk_oe_reg | !res_s;
    data_oe_next = st_reg == bpsc_pkg::ST_RUN && exp_m && data_drive;
  end

  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= bpsc_pkg::ST_RUN;
      cnt_reg <= bpsc_pkg::CNT_RST;
      clk_oe_reg <= 1'b0;
      data_oe_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      clk_oe_reg <= clk_oe_next;
      data_oe_reg <= data_oe_next;
    end
  end

  assign cnt_done = cnt_reg == bpsc_pkg::CNT_LAST;
  assign clk_pin_oe = clk_oe_reg;
  assign data_oe = data_oe_reg;

  // ----------------------------------------------------------------
  // Action of a pin from its role and the pin state
  // ----------------------------------------------------------------
  function automatic bpsc_pkg::bpsc_act_e act_of(
    input bpsc_pkg::bpsc_role_e role,
    input bpsc_pkg::bpsc_state_e st,
    input logic keep
  );
    case (st)
      bpsc_pkg::ST_RUN:
        act_of = role == bpsc_pkg::ROLE_IO ? bpsc_pkg::ACT_PORT
                                           : bpsc_pkg::ACT_DRIVE;
      bpsc_pkg::ST_SWSTBY:
        if (role == bpsc_pkg::ROLE_IO) begin
          act_of = bpsc_pkg::ACT_KEEP;
        end else if (role == bpsc_pkg::ROLE_ADDR) begin
          act_of = keep ? bpsc_pkg::ACT_KEEP : bpsc_pkg::ACT_FLOAT;
        end else begin
          act_of = keep ? bpsc_pkg::ACT_HIGH : bpsc_pkg::ACT_FLOAT;
        end
      bpsc_pkg::ST_RELEASE:
        act_of = role == bpsc_pkg::ROLE_IO ? bpsc_pkg::ACT_KEEP
                                           : bpsc_pkg::ACT_FLOAT;
      default:
        act_of = bpsc_pkg::ACT_FLOAT;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin roles and function values
  // ----------------------------------------------------------------
  bpsc_pkg::bpsc_role_e role [bpsc_pkg::NPIN];
  bpsc_pkg::bpsc_act_e act [bpsc_pkg::NPIN];
  logic [bpsc_pkg::NPIN-1:0] fn_val;
  logic [bpsc_pkg::NPIN-1:0] port_val;
  logic [bpsc_pkg::NPIN-1:0] port_dir;
  logic [bpsc_pkg::NPIN-1:0] pin_out;
  logic [bpsc_pkg::NPIN-1:0] pin_oe;
  logic [2:0] a_sel;
  logic row4_m;
  logic col_m;

  assign a_sel = {addr_bit23_port_select, addr_bit22_port_select,
                  addr_bit21_port_select};
  assign row4_m = dram_area_field == bpsc_pkg::DRAM_AREA_4 ||
                  dram_area_field == bpsc_pkg::DRAM_AREA_5 ||
                  dram_area_field == bpsc_pkg::DRAM_AREA_6;
  assign col_m = |dram_area_field && !column_strobe_select;
  assign port_val = {pb_port_val, pa_port_val};
  assign port_dir = {pb_port_dir, pa_port_dir};

  // Role each shared pin plays in the current mode
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      role[i] = addr_m && !a_sel[i] ? bpsc_pkg::ROLE_ADDR
                                    : bpsc_pkg::ROLE_IO;
    end
    role[bpsc_pkg::PIN_PA7] = m34 || (mode_s == bpsc_pkg::MODE_5 &&
                              !addr_bit20_port_select) ?
                              bpsc_pkg::ROLE_ADDR : bpsc_pkg::ROLE_IO;
    role[bpsc_pkg::PIN_PB0] = exp_m && select6_enable ?
                              bpsc_pkg::ROLE_SEL : bpsc_pkg::ROLE_IO;
    role[bpsc_pkg::PIN_PB1] = exp_m && select7_enable ?
                              bpsc_pkg::ROLE_SEL : bpsc_pkg::ROLE_IO;
    if (!exp_m) begin
      role[bpsc_pkg::PIN_PB2] = bpsc_pkg::ROLE_IO;
    end else if (dram_area_field == bpsc_pkg::DRAM_AREA_5) begin
      role[bpsc_pkg::PIN_PB2] = bpsc_pkg::ROLE_ROW;
    end else begin
      role[bpsc_pkg::PIN_PB2] = select5_enable ? bpsc_pkg::ROLE_SEL
                                               : bpsc_pkg::ROLE_IO;
    end
    if (!exp_m) begin
      role[bpsc_pkg::PIN_PB3] = bpsc_pkg::ROLE_IO;
    end else if (row4_m) begin
      role[bpsc_pkg::PIN_PB3] = bpsc_pkg::ROLE_ROW;
    end else begin
      role[bpsc_pkg::PIN_PB3] = select4_enable ? bpsc_pkg::ROLE_SEL
                                               : bpsc_pkg::ROLE_IO;
    end
    role[bpsc_pkg::PIN_PB4] = exp_m && col_m ? bpsc_pkg::ROLE_COL
                                             : bpsc_pkg::ROLE_IO;
    role[bpsc_pkg::PIN_PB5] = role[bpsc_pkg::PIN_PB4];
  end

  // Value driven while a pin plays its bus role
  always_comb begin
    fn_val[2:0] = addr_in[23:21];
    fn_val[bpsc_pkg::PIN_PA7] = addr_in[20];
    fn_val[bpsc_pkg::PIN_PB0] = select_in_n[6];
    fn_val[bpsc_pkg::PIN_PB1] = select_in_n[7];
    fn_val[bpsc_pkg::PIN_PB2] = role[bpsc_pkg::PIN_PB2] ==
      bpsc_pkg::ROLE_ROW ? row_strobe5 : select_in_n[5];
    fn_val[bpsc_pkg::PIN_PB3] = role[bpsc_pkg::PIN_PB3] ==
      bpsc_pkg::ROLE_ROW ? row_strobe4 : select_in_n[4];
    fn_val[bpsc_pkg::PIN_PB4] = lower_column_strobe;
    fn_val[bpsc_pkg::PIN_PB5] = upper_column_strobe;
  end

  // One cell per shared pin; reset floats them, PA7 goes low late in modes 3 and 4
  generate
    for (genvar g = 0; g < bpsc_pkg::NPIN; g++) begin : g_pin
      always_comb begin
        if (st_reg == bpsc_pkg::ST_RESET) begin
          act[g] = g == bpsc_pkg::PIN_PA7 && m34 && cnt_done ?
                   bpsc_pkg::ACT_LOW : bpsc_pkg::ACT_FLOAT;
        end else begin
          act[g] = act_of(role[g], st_reg, standby_output_keep);
        end
      end
      bpsc_pin_cell #(.W(1)) u_cell (
        .clk(clk),
        .rst(rst),
        .act(act[g]),
        .fn_val(fn_val[g]),
        .port_val(port_val[g]),
        .port_dir(port_dir[g]),
        .pin_out(pin_out[g]),
        .pin_oe(pin_oe[g])
      );
    end
  endgenerate

  assign pa_out = pin_out[3:0];
  assign pa_oe = pin_oe[3:0];
  assign pb_out = pin_out[9:4];
  assign pb_oe = pin_oe[9:4];

  // ----------------------------------------------------------------
  // Low address bus and bus strobes
  // ----------------------------------------------------------------
  bpsc_pkg::bpsc_act_e lo_act;
  bpsc_pkg::bpsc_act_e stb_act;
  bpsc_pkg::bpsc_act_e cs0_act;
  bpsc_pkg::bpsc_role_e bus_role;
  bpsc_pkg::bpsc_role_e cs0_role;
  logic [3:0] stb_out;
  logic [3:0] stb_oe;

  // Reset: strobes high in expanded modes, low address waits for the counter in modes 1 to 4
  always_comb begin
    bus_role = exp_m ? bpsc_pkg::ROLE_SEL : bpsc_pkg::ROLE_IO;
    cs0_role = m14 ? bpsc_pkg::ROLE_SEL : bpsc_pkg::ROLE_IO;
    if (st_reg == bpsc_pkg::ST_RESET) begin
      lo_act = m14 && cnt_done ? bpsc_pkg::ACT_LOW
                               : bpsc_pkg::ACT_FLOAT;
      stb_act = exp_m ? bpsc_pkg::ACT_HIGH : bpsc_pkg::ACT_FLOAT;
      cs0_act = m14 ? bpsc_pkg::ACT_HIGH : bpsc_pkg::ACT_FLOAT;
    end else begin
      lo_act = act_of(exp_m ? bpsc_pkg::ROLE_ADDR : bpsc_pkg::ROLE_IO,
                      st_reg, standby_output_keep);
      stb_act = act_of(bus_role, st_reg, standby_output_keep);
      cs0_act = act_of(cs0_role, st_reg, standby_output_keep);
    end
  end

  bpsc_pin_cell #(.W(20)) u_addr_lo (
    .clk(clk),
    .rst(rst),
    .act(lo_act),
    .fn_val(addr_in[19:0]),
    .port_val(20'h00000),
    .port_dir(20'h00000),
    .pin_out(addr_lo_out),
    .pin_oe()
  );

  // Whole low bus shares one enable, taken from a separate one-bit cell
  bpsc_pin_cell #(.W(1)) u_addr_lo_oe (
    .clk(clk),
    .rst(rst),
    .act(lo_act),
    .fn_val(1'b1),
    .port_val(1'b0),
    .port_dir(1'b0),
    .pin_out(),
    .pin_oe(addr_lo_oe)
  );

  bpsc_pin_cell #(.W(4)) u_strobes (
    .clk(clk),
    .rst(rst),
    .act(stb_act),
    .fn_val({addr_strobe_in_n, read_in_n, high_write_in_n,
             low_write_in_n}),
    .port_val(4'h0),
    .port_dir(4'h0),
    .pin_out(stb_out),
    .pin_oe(stb_oe)
  );

  bpsc_pin_cell #(.W(1)) u_select0 (
    .clk(clk),
    .rst(rst),
    .act(cs0_act),
    .fn_val(select0_in_n),
    .port_val(1'b0),
    .port_dir(1'b0),
    .pin_out(select0_n),
    .pin_oe(select0_oe)
  );

  assign {addr_strobe_n, read_n, high_write_n, low_write_n} = stb_out;
  assign strobes_oe = stb_oe[3];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  hwstby_float_a: assert property (
    st_reg == bpsc_pkg::ST_HWSTBY |=> pin_oe == '0 && !addr_lo_oe &&
    !strobes_oe && !select0_oe && !data_oe)
    else $error("pins driven in hardware standby");
  addr_run_a: assert property (
    st_reg == bpsc_pkg::ST_RUN && addr_m && !addr_bit23_port_select
    |=> pa_oe[2] && pa_out[2] == $past(addr_in[23]))
    else $error("upper address pin not driving");
  addr_sw_float_a: assert property (
    st_reg == bpsc_pkg::ST_SWSTBY && !standby_output_keep &&
    role[0] == bpsc_pkg::ROLE_ADDR |=> !pa_oe[0])
    else $error("address pin not floating in standby");
  a20_mode5_a: assert property (
    st_reg == bpsc_pkg::ST_RUN && mode_s == bpsc_pkg::MODE_5 &&
    !addr_bit20_port_select |=> pa_oe[3] && pa_out[3] == $past(addr_in[20]))
    else $error("A20 pin not driving in mode 5");
  sel_sw_high_a: assert property (
    st_reg == bpsc_pkg::ST_SWSTBY && standby_output_keep &&
    role[bpsc_pkg::PIN_PB0] == bpsc_pkg::ROLE_SEL |=> pb_oe[0] && pb_out[0])
    else $error("select pin not high in standby");
  port_keep_a: assert property (
    st_reg == bpsc_pkg::ST_RELEASE &&
    role[bpsc_pkg::PIN_PB1] == bpsc_pkg::ROLE_IO
    |=> $stable(pb_oe[1]) && $stable(pb_out[1]))
    else $error("port pin changed in bus release");
  row5_a: assert property (
    st_reg == bpsc_pkg::ST_RUN && exp_m &&
    dram_area_field == bpsc_pkg::DRAM_AREA_5
    |=> pb_oe[2] && pb_out[2] == $past(row_strobe5))
    else $error("row strobe 5 missing");
  row4_a: assert property (
    st_reg == bpsc_pkg::ST_RUN && exp_m && row4_m
    |=> pb_oe[3] && pb_out[3] == $past(row_strobe4))
    else $error("row strobe 4 missing");
  col_release_a: assert property (
    st_reg == bpsc_pkg::ST_RELEASE && exp_m && col_m |=> pb_oe[5:4] == 2'h0)
    else $error("column strobes driven in release");
  reset_bus_a: assert property (
    st_reg == bpsc_pkg::ST_RESET && exp_m
    |=> strobes_oe && stb_out == 4'hf && !data_oe)
    else $error("strobes not high in reset");
  addr_init_a: assert property (
    (st_reg == bpsc_pkg::ST_RESET && cnt_reg == 2'h0 && m14)
    ##1 (!addr_lo_oe && st_reg == bpsc_pkg::ST_RESET)
    ##1 (!addr_lo_oe && st_reg == bpsc_pkg::ST_RESET)
    |=> addr_lo_oe && addr_lo_out == 20'h00000)
    else $error("address bus not low on time");
  reset_float_a: assert property (
    st_reg == bpsc_pkg::ST_RESET && m34 |=> pa_oe[2:0] == 3'h0 &&
    pb_oe[1:0] == 2'h0)
    else $error("port bus pins driven in reset");
  mode5_float_a: assert property (
    st_reg == bpsc_pkg::ST_RESET && mode_s == bpsc_pkg::MODE_5
    |=> !addr_lo_oe && !data_oe)
    else $error("address bus driven in mode 5 reset");
  clk_pin_a: assert property (
    !res_s |=> clk_pin_oe)
    else $error("clock pin not output after reset");
  single_keep_a: assert property (
    st_reg == bpsc_pkg::ST_SWSTBY && !exp_m |=> $stable(pin_oe))
    else $error("single-chip pin changed in standby");

  release_c: cover property (st_reg == bpsc_pkg::ST_RELEASE && exp_m);
  dram_run_c: cover property (st_reg == bpsc_pkg::ST_RUN && col_m && exp_m);
  reset_low_c: cover property (addr_lo_oe && st_reg == bpsc_pkg::ST_RESET);
  sw_keep_c: cover property (st_reg == bpsc_pkg::ST_SWSTBY &&
                             standby_output_keep && m34);

endmodule

//--- bench/bpsc_ext_mem.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Expansion bus partner: select and strobe lines with pull-ups
// ----------------------------------------------------------------
module bpsc_ext_mem (
  input wire logic [5:0] pb_out,
  input wire logic [5:0] pb_oe,
  output logic [5:0] pb_wire
);
  // Released lines settle at the pull-up level
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      pb_wire[k] = pb_oe[k] ? pb_out[k] : 1'b1;
    end
  end
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk = 0, rst = 1, reset_n = 1, hw_standby_n = 1, sw_standby = 0;
  logic bus_release = 0, standby_output_keep = 0, data_drive = 0;
  logic addr_bit23_port_select = 0, addr_bit22_port_select = 0;
  logic addr_bit21_port_select = 0, addr_bit20_port_select = 0;
  logic select7_enable = 0, select6_enable = 0, select5_enable = 0;
  logic select4_enable = 0, column_strobe_select = 0, row_strobe5 = 0;
  logic row_strobe4 = 0, upper_column_strobe = 0, lower_column_strobe = 0;
  logic addr_strobe_in_n = 1, read_in_n = 1, high_write_in_n = 1;
  logic low_write_in_n = 1, select0_in_n = 1;
  logic [2:0] op_mode = 3'h3, dram_area_field = 3'h0;
  logic [23:0] addr_in = 24'h0;
  logic [7:4] select_in_n = 4'hf;
  logic [3:0] pa_port_val = 4'h0, pa_port_dir = 4'h0, pa_out, pa_oe, pa_old;
  logic [5:0] pb_port_val = 6'h0, pb_port_dir = 6'h0, pb_out, pb_oe, pb_old;
  logic [19:0] addr_lo_out;
  logic [5:0] pb_wire;
  logic addr_lo_oe, addr_strobe_n, read_n, high_write_n, low_write_n;
  logic strobes_oe, select0_n, select0_oe, data_oe, clk_pin_oe;
  integer seed = 12982, miscompares = 0, checks = 0, i;

  bpsc_top DUT (.clk, .rst, .reset_n, .hw_standby_n, .op_mode, .sw_standby,
    .bus_release, .standby_output_keep, .addr_bit23_port_select,
    .addr_bit22_port_select, .addr_bit21_port_select, .addr_bit20_port_select,
    .select7_enable, .select6_enable, .select5_enable, .select4_enable,
    .dram_area_field, .column_strobe_select, .addr_in, .select_in_n,
    .row_strobe5, .row_strobe4, .upper_column_strobe, .lower_column_strobe,
    .addr_strobe_in_n, .read_in_n, .high_write_in_n, .low_write_in_n,
    .select0_in_n, .data_drive, .pa_port_val, .pa_port_dir, .pb_port_val,
    .pb_port_dir, .pa_out, .pa_oe, .pb_out, .pb_oe, .addr_lo_out, .addr_lo_oe,
    .addr_strobe_n, .read_n, .high_write_n, .low_write_n, .strobes_oe,
    .select0_n, .select0_oe, .data_oe, .clk_pin_oe);

  bpsc_ext_mem mem (.pb_out, .pb_oe, .pb_wire);

  // Clock of 100 ns
  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // Checking and expectation helpers
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [11:0] mix(input logic [5:0] u, f, v, d);
    logic [5:0] oe;
    oe = u | d;
    return {oe, (u & f | ~u & v) & oe};
  endfunction

  function automatic logic [11:0] exp_pb();
    logic r5, r4, cs, sc;
    r5 = dram_area_field == 3'h5;
    r4 = dram_area_field inside {3'h4, 3'h5, 3'h6};
    cs = |dram_area_field & ~column_strobe_select;
    sc = op_mode < 3'h6;
    return mix({6{sc}} & {cs, cs, r4 | select4_enable, r5 | select5_enable,
      select7_enable, select6_enable}, {upper_column_strobe,
      lower_column_strobe, r4 ? row_strobe4 : select_in_n[4],
      r5 ? row_strobe5 : select_in_n[5], select_in_n[7], select_in_n[6]},
      pb_port_val, pb_port_dir);
  endfunction

  function automatic logic [11:0] exp_pa();
    logic [3:0] u;
    u = {op_mode == 3'h5 ? ~addr_bit20_port_select : 1'b1,
      ~addr_bit23_port_select, ~addr_bit22_port_select,
      ~addr_bit21_port_select} & {4{op_mode inside {[3'h3:3'h5]}}};
    return mix({2'h0, u}, {2'h0, addr_in[20], addr_in[23:21]},
      {2'h0, pa_port_val}, {2'h0, pa_port_dir});
  endfunction

  // Random setting of every configuration and function input but the standby and release controls
  task rnd;
    logic [31:0] r, a, b;
    r = $random(seed);
    a = $random(seed);
    b = $random(seed);
    @(posedge clk);
    {addr_bit23_port_select, addr_bit22_port_select, addr_bit21_port_select,
      addr_bit20_port_select, select7_enable, select6_enable, select5_enable,
      select4_enable, column_strobe_select} <= r[8:0];
    dram_area_field <= r[11:9];
    {select_in_n, row_strobe5, row_strobe4, upper_column_strobe,
      lower_column_strobe} <= r[19:12];
    {pa_port_val, pa_port_dir} <= r[27:20];
    op_mode <= (r[30:28] == 3'h0) ? 3'h3 : r[30:28];
    addr_in <= a[23:0];
    {addr_strobe_in_n, read_in_n, high_write_in_n, low_write_in_n,
      select0_in_n, data_drive} <= a[29:24];
    {pb_port_val, pb_port_dir} <= b[11:0];
  endtask

  task settle;
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask

  task go(input logic sw, input logic rel, input logic keep);
    @(posedge clk);
    sw_standby <= sw;
    bus_release <= rel;
    standby_output_keep <= keep;
    settle;
  endtask

  task close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #(2000 * 100);
    miscompares++;
    close_out;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 40; i++) begin
      rnd;
      if (i < 16) begin
        @(posedge clk);
        dram_area_field <= i[2:0];
        column_strobe_select <= i[3];
      end
      settle;
      chk({pb_oe, pb_out & pb_oe}, exp_pb());
      chk({2'h0, pa_oe, 2'h0, pa_out & pa_oe}, exp_pa());
      chk({data_oe, addr_lo_oe, strobes_oe, select0_oe}, {data_drive &
        (op_mode < 3'h6), {2{op_mode < 3'h6}}, op_mode < 3'h5});
    end
    // Every pin in its bus role, then standby and release
    @(posedge clk);
    op_mode <= 3'h3;
    dram_area_field <= 3'h5;
    {column_strobe_select, addr_bit23_port_select, addr_bit22_port_select,
      addr_bit21_port_select} <= 4'h0;
    {select7_enable, select6_enable} <= 2'h3;
    settle;
    pa_old = pa_out;
    go(1'b1, 1'b0, 1'b1);
    @(posedge clk);
    addr_in <= ~addr_in;
    settle;
    chk({pb_oe, pb_out}, 12'hfff);
    chk({pa_oe, pa_out}, {4'hf, pa_old});
    go(1'b1, 1'b0, 1'b0);
    chk({pb_oe, pa_oe}, 0);
    go(1'b0, 1'b1, 1'b0);
    chk({pb_oe, pa_oe}, 0);
    chk(pb_wire, 6'h3f);
    go(1'b0, 1'b0, 1'b0);
    // Plain port pins hold through release and standby
    @(posedge clk);
    dram_area_field <= 3'h0;
    column_strobe_select <= 1'b1;
    {select7_enable, select6_enable, select5_enable, select4_enable} <= 4'h0;
    pb_port_dir <= 6'h3f;
    settle;
    pb_old = pb_out;
    go(1'b0, 1'b1, 1'b0);
    @(posedge clk);
    pb_port_val <= ~pb_port_val;
    settle;
    chk({pb_oe, pb_out}, {6'h3f, pb_old});
    go(1'b1, 1'b0, 1'b0);
    chk({pb_oe, pb_out}, {6'h3f, pb_old});
    go(1'b0, 1'b0, 1'b0);
    // Single-chip mode keeps every port pin, even with the keep bit set
    @(posedge clk);
    op_mode <= 3'h7;
    settle;
    {pa_old, pb_old} = {pa_out, pb_out};
    go(1'b1, 1'b0, 1'b1);
    @(posedge clk);
    {pa_port_val, pb_port_val} <= ~{pa_port_val, pb_port_val};
    settle;
    chk({pa_oe, pa_out, pb_oe, pb_out},
      {pa_port_dir, pa_old, 6'h3f, pb_old});
    go(1'b0, 1'b0, 1'b0);
    // Hardware standby releases every bus and port pin
    @(posedge clk);
    hw_standby_n <= 1'b0;
    settle;
    chk({pa_oe, pb_oe, addr_lo_oe, strobes_oe, select0_oe, data_oe}, 0);
    @(posedge clk);
    hw_standby_n <= 1'b1;
    op_mode <= 3'h3;
    settle;
    // Reset pin in mode 3 with address pins on port A
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk({strobes_oe, addr_strobe_n, read_n, high_write_n, low_write_n,
      select0_n, select0_oe, data_oe, clk_pin_oe, addr_lo_oe}, 10'h3fa);
    chk({pa_oe, pb_oe}, 0);
    @(negedge clk);
    chk({pa_oe[3], pa_out[3], addr_lo_oe, addr_lo_out}, 23'h500000);
    // Reset pin released, then reset again in mode 5
    @(posedge clk);
    reset_n <= 1'b1;
    op_mode <= 3'h5;
    settle;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) settle;
    chk({strobes_oe, addr_strobe_n, read_n, high_write_n, low_write_n,
      select0_oe, addr_lo_oe, data_oe, pa_oe[3]}, 9'h1f0);
    close_out;
  end
endmodule
